// ==== shared/sclk_pkg.sv ====
package sclk_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SYS_CLK_CTRL_IDX   = 8'h0d;
    localparam logic [9:0] SYS_CLK_CTRL_ADDR  = 10'h034;
    localparam logic [9:0] MODE_STATUS_ADDR   = 10'h040;
    localparam logic [9:0] EVENT_CTRL_ADDR    = 10'h044;
    localparam logic [6:0] SYS_CLK_CTRL_RESET = 7'h01;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PLL_MULT_LSB  = 4;
    localparam int HALT_KIND_BIT = 3;
    localparam int BOOST_LSB     = 1;
    localparam int CPU_SRC_BIT   = 0;
    localparam int EV_HALT_BIT   = 0;
    localparam int EV_WAKE_BIT   = 1;
    localparam int EV_WDT_BIT    = 2;

    // ------------------------------------------------------------
    // Multiplier codes
    // ------------------------------------------------------------
    localparam logic [2:0] MULT_X130   = 3'h0;
    localparam logic [2:0] MULT_X65    = 3'h1;
    localparam logic [2:0] MULT_X65_2  = 3'h2;
    localparam logic [2:0] MULT_X65_4  = 3'h3;
    localparam logic [1:0] SEL_X130    = 2'h0;
    localparam logic [1:0] SEL_X65     = 2'h1;
    localparam logic [1:0] SEL_X244    = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int FIXED_WAIT_MS    = 18;
    localparam int FIXED_WAIT_CYC   = FIXED_WAIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SUB_SETTLE_TICKS = 15;
    localparam int MAIN_SETTLE_TICKS = 11;
    localparam int OSC_START_CYC    = 64;

    typedef enum logic [2:0] {
        SCLK_ST_RESET_WAIT,
        SCLK_ST_NORMAL,
        SCLK_ST_GREEN,
        SCLK_ST_IDLE,
        SCLK_ST_SLEEP,
        SCLK_ST_START_WAIT
    } sclk_mode_type;

    typedef struct packed {
        logic [1:0] pll_sel;
        logic [1:0] pll_div_shift;
        logic [1:0] boost_div_sel;
        logic       cpu_on_main;
        logic       main_osc_en;
        logic       sub_osc_en;
        logic       cpu_run;
    } sclk_clk_out_type;

    typedef struct packed {
        logic main_timer_run;
        logic sub_timer_run;
        logic pin_timer_run;
        logic pin_timer_wake_en;
    } sclk_timer_out_type;

endpackage : sclk_pkg

// ==== logic/sclk_mode_ctrl.sv ====
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module sclk_mode_ctrl #(
    parameter int FIXED_WAIT = sclk_pkg::FIXED_WAIT_CYC,
    parameter int OSC_START  = sclk_pkg::OSC_START_CYC
) (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    input  wire logic                         sub_osc_tick,
    input  wire logic                         main_osc_tick,
    input  wire logic                         wake_event,
    input  wire logic                         wdt_enabled,
    output sclk_pkg::sclk_clk_out_type        clk_ctrl,
    output sclk_pkg::sclk_timer_out_type      timer_ctrl
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [6:0]              ctrl;
        logic                    ap_valid;
        logic                    ap_write;
        logic [9:0]              ap_addr;
        logic [31:0]             rdata;
        sclk_pkg::sclk_mode_type mode;
        sclk_pkg::sclk_mode_type target;
        logic                    sleep_wdt;
        logic [31:0]             fixed_cnt;
        logic [15:0]             osc_cnt;
        logic [4:0]              tick_cnt;
        logic                    use_main_ticks;
        logic                    event_halt;
        logic                    event_wake;
        sclk_pkg::sclk_clk_out_type   clk_out;
        sclk_pkg::sclk_timer_out_type tmr_out;
    } sclk_state_type;

    sclk_state_type s_q;
    sclk_state_type s_d;

    function automatic logic [1:0] pll_sel_of(input logic [2:0] code);
        if (code[2]) begin
            pll_sel_of = sclk_pkg::SEL_X244;
        end else if (code == sclk_pkg::MULT_X130) begin
            pll_sel_of = sclk_pkg::SEL_X130;
        end else begin
            pll_sel_of = sclk_pkg::SEL_X65;
        end
    endfunction : pll_sel_of

    function automatic logic [1:0] pll_shift_of(input logic [2:0] code);
        case (code)
            sclk_pkg::MULT_X65_2: pll_shift_of = 2'h1;
            sclk_pkg::MULT_X65_4: pll_shift_of = 2'h2;
            default:              pll_shift_of = 2'h0;
        endcase
    endfunction : pll_shift_of

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       wr_ok;
        logic       rd_ok;
        logic       halt_go;
        logic       wake_go;
        logic [2:0] mult;
        logic       running;
        mult    = 3'h0;
        running = 1'b0;
        s_d     = s_q;
        wr_ok   = s_q.ap_valid && s_q.ap_write;
        halt_go = 1'b0;
        wake_go = 1'b0;
        rd_ok   = hsel && hready && htrans[1] && !hwrite;
        s_d.ap_valid = hsel && hready && htrans[1];
        if (hready) begin
            s_d.ap_write = hwrite;
            s_d.ap_addr  = haddr[9:0];
        end
        if (wr_ok && s_q.ap_addr == sclk_pkg::SYS_CLK_CTRL_ADDR) begin
            s_d.ctrl = hwdata[6:0];
        end
        if (wr_ok && s_q.ap_addr == sclk_pkg::EVENT_CTRL_ADDR) begin
            halt_go = hwdata[sclk_pkg::EV_HALT_BIT];
            wake_go = hwdata[sclk_pkg::EV_WAKE_BIT];
            s_d.sleep_wdt = hwdata[sclk_pkg::EV_WDT_BIT];
        end
        wake_go = wake_go || wake_event;
        s_d.rdata = 32'h0;
        if (rd_ok) begin
            case (haddr[9:0])
                sclk_pkg::SYS_CLK_CTRL_ADDR: s_d.rdata = {25'h0, s_q.ctrl};
                sclk_pkg::MODE_STATUS_ADDR:  s_d.rdata = {28'h0, s_q.clk_out.cpu_run, s_q.mode};
                default:                     s_d.rdata = 32'h0;
            endcase
        end
        case (s_q.mode)
            sclk_pkg::SCLK_ST_NORMAL,
            sclk_pkg::SCLK_ST_GREEN: begin
                if (halt_go) begin
                    s_d.sleep_wdt = wdt_enabled;
                    s_d.target = s_q.mode;
                    if (s_q.ctrl[sclk_pkg::HALT_KIND_BIT]) begin
                        s_d.mode = sclk_pkg::SCLK_ST_IDLE;
                    end else begin
                        s_d.mode = sclk_pkg::SCLK_ST_SLEEP;
                    end
                end else if (s_q.mode == sclk_pkg::SCLK_ST_GREEN
                             && s_q.ctrl[sclk_pkg::CPU_SRC_BIT]) begin
                    s_d.mode           = sclk_pkg::SCLK_ST_START_WAIT;
                    s_d.target         = sclk_pkg::SCLK_ST_NORMAL;
                    s_d.osc_cnt        = 16'(OSC_START);
                    s_d.fixed_cnt      = 32'h0;
                    s_d.tick_cnt       = 5'(sclk_pkg::MAIN_SETTLE_TICKS);
                    s_d.use_main_ticks = 1'b1;
                end else if (s_q.mode == sclk_pkg::SCLK_ST_NORMAL
                             && !s_q.ctrl[sclk_pkg::CPU_SRC_BIT]) begin
                    s_d.mode = sclk_pkg::SCLK_ST_GREEN;
                end
            end
            sclk_pkg::SCLK_ST_IDLE,
            sclk_pkg::SCLK_ST_SLEEP: begin
                if (wake_go) begin
                    s_d.target = s_q.ctrl[sclk_pkg::CPU_SRC_BIT] ? sclk_pkg::SCLK_ST_NORMAL
                                                              : sclk_pkg::SCLK_ST_GREEN;
                    s_d.mode           = sclk_pkg::SCLK_ST_START_WAIT;
                    s_d.osc_cnt        = 16'(OSC_START);
                    s_d.tick_cnt       = 5'(sclk_pkg::SUB_SETTLE_TICKS);
                    s_d.use_main_ticks = 1'b0;
                    s_d.fixed_cnt      = (s_q.mode == sclk_pkg::SCLK_ST_SLEEP)
                                         ? 32'(FIXED_WAIT) : 32'h0;
                end
            end
            sclk_pkg::SCLK_ST_RESET_WAIT,
            sclk_pkg::SCLK_ST_START_WAIT: begin
                if (s_q.fixed_cnt != 32'h0) begin
                    s_d.fixed_cnt = s_q.fixed_cnt - 32'h1;
                end else if (s_q.osc_cnt != 16'h0) begin
                    s_d.osc_cnt = s_q.osc_cnt - 16'h1;
                end else if (s_q.tick_cnt != 5'h0) begin
                    if (s_q.use_main_ticks ? main_osc_tick : sub_osc_tick) begin
                        s_d.tick_cnt = s_q.tick_cnt - 5'h1;
                    end
                end else begin
                    s_d.mode = s_q.target;
                end
            end
            default: s_d.mode = sclk_pkg::SCLK_ST_NORMAL;
        endcase

        mult    = s_d.ctrl[sclk_pkg::PLL_MULT_LSB +: 3];
        running = (s_d.mode == sclk_pkg::SCLK_ST_NORMAL) || (s_d.mode == sclk_pkg::SCLK_ST_GREEN);
        s_d.clk_out.pll_sel       = pll_sel_of(mult);
        s_d.clk_out.pll_div_shift = pll_shift_of(mult);
        s_d.clk_out.boost_div_sel = s_d.ctrl[sclk_pkg::BOOST_LSB +: 2];
        s_d.clk_out.cpu_on_main   = (s_d.mode == sclk_pkg::SCLK_ST_NORMAL);
        s_d.clk_out.cpu_run       = running;
        s_d.clk_out.main_osc_en   = s_d.ctrl[sclk_pkg::CPU_SRC_BIT]
                                    && s_d.mode != sclk_pkg::SCLK_ST_SLEEP
                                    && s_d.mode != sclk_pkg::SCLK_ST_IDLE;
        s_d.clk_out.sub_osc_en    = (s_d.mode != sclk_pkg::SCLK_ST_SLEEP);
        s_d.tmr_out.main_timer_run = (s_d.mode == sclk_pkg::SCLK_ST_NORMAL);
        s_d.tmr_out.sub_timer_run  = running
                                     || (s_d.mode == sclk_pkg::SCLK_ST_IDLE)
                                     || (s_d.mode == sclk_pkg::SCLK_ST_SLEEP
                                         && !s_d.sleep_wdt && 1'b0);
        s_d.tmr_out.pin_timer_run     = 1'b1;
        s_d.tmr_out.pin_timer_wake_en = (s_d.mode != sclk_pkg::SCLK_ST_SLEEP);
        s_d.event_halt = halt_go;
        s_d.event_wake = wake_go;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q                <= '0;
            s_q.ctrl           <= sclk_pkg::SYS_CLK_CTRL_RESET;
            s_q.mode           <= sclk_pkg::SCLK_ST_RESET_WAIT;
            s_q.target         <= sclk_pkg::SCLK_ST_NORMAL;
            s_q.fixed_cnt      <= 32'(FIXED_WAIT);
            s_q.osc_cnt        <= 16'(OSC_START);
            s_q.tick_cnt       <= 5'(sclk_pkg::SUB_SETTLE_TICKS);
            s_q.clk_out.sub_osc_en  <= 1'b1;
            s_q.clk_out.main_osc_en <= 1'b1;
            s_q.tmr_out.pin_timer_run <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata     = s_q.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign clk_ctrl   = s_q.clk_out;
    assign timer_ctrl = s_q.tmr_out;

endmodule : sclk_mode_ctrl

`default_nettype wire

// ==== dv/sclk_chk_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module sclk_chk #(
    parameter int FIXED_WAIT = 20,
    parameter int OSC_START  = 4
) (
    input wire logic                         hclk,
    input wire logic                         hresetn,
    input wire logic                         hsel,
    input wire logic [31:0]                  haddr,
    input wire logic [1:0]                   htrans,
    input wire logic                         hwrite,
    input wire logic [31:0]                  hwdata,
    input wire logic                         hready,
    input wire logic [31:0]                  hrdata,
    input wire logic                         hreadyout,
    input wire logic                         hresp,
    input wire sclk_pkg::sclk_clk_out_type   clk_ctrl,
    input wire sclk_pkg::sclk_timer_out_type timer_ctrl
);
    // ------------------------------------------------------------
    // Data phase tracking
    // ------------------------------------------------------------
    localparam int RWAIT = FIXED_WAIT + OSC_START + 15;
    logic       ph_q;
    logic       aw_q;
    logic [9:0] ad_q;
    logic [6:0] c_q;
    logic [7:0] n_q;
    wire logic  wc = ph_q && aw_q && ad_q == sclk_pkg::SYS_CLK_CTRL_ADDR;
    wire logic  hv = ph_q && aw_q && ad_q == sclk_pkg::EVENT_CTRL_ADDR && hwdata[0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 1'b0;
            aw_q <= 1'b0;
            ad_q <= 10'h0;
            c_q  <= sclk_pkg::SYS_CLK_CTRL_RESET;
            n_q  <= 8'h0;
        end else begin
            ph_q <= hsel && hready && htrans[1];
            aw_q <= hwrite;
            ad_q <= haddr[9:0];
            c_q  <= wc ? hwdata[6:0] : c_q;
            n_q  <= n_q + {7'h0, n_q != 8'hff};
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_halt;
        hv;
    endsequence
    a_boost_sel: assert property (wc |=> ##[0:1]
        clk_ctrl.boost_div_sel == c_q[2:1]) else $error("booster select wrong");
    a_pll_low: assert property (wc && !hwdata[6] |=> ##[0:1]
        clk_ctrl.pll_sel == {1'b0, |c_q[5:4]}
        && clk_ctrl.pll_div_shift == (c_q[5] ? c_q[5:4] - 2'h1 : 2'h0))
        else $error("multiplier select wrong");
    a_pll_top: assert property (wc && hwdata[6] |=> ##[0:1]
        clk_ctrl.pll_sel == sclk_pkg::SEL_X244) else $error("top multiplier wrong");
    a_halt_sleep: assert property (s_halt ##0 !c_q[3] |-> ##[1:4]
        !clk_ctrl.sub_osc_en) else $error("halt did not sleep");
    a_halt_idle: assert property (s_halt ##0 c_q[3] |-> ##[1:4]
        (clk_ctrl.sub_osc_en && !clk_ctrl.cpu_run)) else $error("halt did not idle");
    a_sleep_all: assert property (!clk_ctrl.sub_osc_en |->
        !clk_ctrl.main_osc_en && !clk_ctrl.cpu_run && !timer_ctrl.sub_timer_run
        && !timer_ctrl.pin_timer_wake_en) else $error("sleep left something on");
    a_sub_main_off: assert property (clk_ctrl.cpu_run && !c_q[0]
        |-> !clk_ctrl.main_osc_en) else $error("main oscillator not stopped");
    a_main_timer: assert property (timer_ctrl.main_timer_run |->
        clk_ctrl.cpu_run && clk_ctrl.cpu_on_main) else $error("main timer early");
    a_sub_timer: assert property ($rose(timer_ctrl.sub_timer_run) |->
        clk_ctrl.cpu_run) else $error("sub timer resumed early");
    a_reset_wait: assert property (n_q < RWAIT |->
        !clk_ctrl.cpu_run) else $error("cpu ran before reset wait");
    a_rdata_idle: assert property (!(ph_q && !aw_q) |->
        hrdata == 32'h0 && hreadyout && !hresp) else $error("bus outputs wrong");
endmodule : sclk_chk
bind sclk_mode_ctrl sclk_chk #(.FIXED_WAIT(FIXED_WAIT), .OSC_START(OSC_START)) u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .clk_ctrl, .timer_ctrl);
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int FW = 20;
    localparam int OS = 4;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd, rd_s, d;
    logic [3:0]  e;
    logic        hreadyout, hresp;
    logic        sub_t = 1'b0, main_t = 1'b0, wake = 1'b0, wdt = 1'b0;
    logic [7:0]  tk = 8'h0;
    int          n_errors = 0, n_tests = 0, cyc;
    sclk_pkg::sclk_clk_out_type   cc;
    sclk_pkg::sclk_timer_out_type tc;
    sclk_mode_ctrl #(.FIXED_WAIT(FW), .OSC_START(OS)) dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .sub_osc_tick(sub_t), .main_osc_tick(main_t), .wake_event(wake),
        .wdt_enabled(wdt), .clk_ctrl(cc), .timer_ctrl(tc));
    // ------------------------------------------------------------
    // Clock, oscillator ticks and bus tasks
    // ------------------------------------------------------------
    initial begin
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        tk <= tk + 8'h1;
        sub_t <= tk[1:0] == 2'h3;
        main_t <= tk[0];
        rd_s <= hrdata;
    end
    task automatic end_of_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (i == 50) begin
            n_errors++;
            end_of_test;
        end
    endtask : step
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        step;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        step;
        #1;
        rd = rd_s;
    endtask : bus
    task automatic wrun;
        cyc = 0;
        while ({cc.cpu_run, cc.cpu_on_main} !== 2'b11 && cyc < 3000) begin
            @(posedge hclk);
            #1;
            cyc++;
        end
        if (cyc == 3000) begin
            n_errors++;
            end_of_test;
        end
    endtask : wrun
    task automatic idle3;
        repeat (3) @(posedge hclk);
        #1;
    endtask : idle3
    task automatic pulse_wake;
        wake <= 1'b1;
        @(posedge hclk);
        wake <= 1'b0;
    endtask : pulse_wake
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 10'h034, 32'h0);
        chk(rd, 32'h1);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        bus(1'b0, 10'h040, 32'h0);
        chk(rd, 32'h0);
        wrun;
        chk({31'h0, cyc >= FW + OS + 48}, 32'h1);
        for (int k = 0; k < 8; k++) begin
            d = {25'h0, k[2:0], 1'b0, k[1:0], 1'b1};
            bus(1'b1, 10'h034, d);
            bus(1'b0, 10'h034, 32'h0);
            chk(rd, d);
            e = k[2] ? {sclk_pkg::SEL_X244, 2'h0}
                     : {1'b0, |k[1:0], (k[1] ? k[1:0] - 2'h1 : 2'h0)};
            chk({26'h0, cc.pll_sel, cc.pll_div_shift, cc.boost_div_sel}, {26'h0, e, k[1:0]});
        end
        bus(1'b1, 10'h03c, 32'h7f);
        bus(1'b0, 10'h03c, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 10'h034, 32'h0);
        chk(rd, d);
        bus(1'b1, 10'h034, 32'h0);
        idle3;
        chk({30'h0, cc.cpu_on_main, cc.main_osc_en}, 32'h0);
        bus(1'b0, 10'h040, 32'h0);
        chk(rd, 32'ha);
        bus(1'b1, 10'h034, 32'h1);
        wrun;
        chk({31'h0, cyc >= OS + 19}, 32'h1);
        bus(1'b1, 10'h034, 32'h9);
        bus(1'b1, 10'h044, 32'h1);
        idle3;
        chk({30'h0, cc.cpu_run, cc.sub_osc_en}, 32'h1);
        bus(1'b0, 10'h040, 32'h0);
        chk(rd, 32'h3);
        pulse_wake;
        wrun;
        chk({31'h0, cyc >= OS + 54}, 32'h1);
        wdt <= 1'b1;
        bus(1'b1, 10'h034, 32'h1);
        bus(1'b1, 10'h044, 32'h1);
        idle3;
        chk({25'h0, cc.sub_osc_en, cc.main_osc_en, cc.cpu_run, tc}, 32'h2);
        bus(1'b0, 10'h040, 32'h0);
        chk(rd, 32'h4);
        pulse_wake;
        wrun;
        chk({31'h0, cyc >= FW + OS + 54}, 32'h1);
        idle3;
        chk({28'h0, tc}, 32'hf);
        end_of_test;
    end
endmodule : testbench
`default_nettype wire
